/* File: include/ldc_map.svh */
// Purpose: Command identifiers, field positions, reset values and timing for the LED command bank
// Assumes: 16-bit command words, 48-bit data words, MSB first on the serial link
// Notes: Definitions only
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH

// ==========================================
// Command identifiers
`define LDC_CMD_CFG0_WR 16'hAA00
`define LDC_CMD_CFG0_RD 16'hAA60
`define LDC_CMD_OPEN_SEL_WR 16'hAA0E
`define LDC_CMD_OPEN_SEL_RD 16'hAA6E
`define LDC_CMD_SHORT_SEL_WR 16'hAA0F
`define LDC_CMD_SHORT_SEL_RD 16'hAA6F
`define LDC_CMD_OPEN_UP_RD 16'hAAA0
`define LDC_CMD_OPEN_LO_RD 16'hAAA1
`define LDC_CMD_SHORT_UP_RD 16'hAAA2
`define LDC_CMD_SHORT_LO_RD 16'hAAA3
`define LDC_CMD_OPEN_CH_RD 16'hAAA4
`define LDC_CMD_SHORT_CH_RD 16'hAAA5
`define LDC_CMD_VSYNC 16'hAAF0
`define LDC_CMD_PSAVE 16'hAA90
`define LDC_CMD_STBY_CLEAR 16'hAAB0
`define LDC_CMD_STBY_ENTER 16'hAAB1
`define LDC_CMD_SRESET 16'hAA80
`define LDC_CMD_SRAM 16'hAA30

// ==========================================
// First configuration word fields and reset
`define LDC_CNT_LSB 0
`define LDC_CNT_MSB 4
`define LDC_PDC_BIT 8
`define LDC_SCAN_LSB 16
`define LDC_SCAN_MSB 21
`define LDC_CFG0_RST 48'h2000_E000_0107

// ==========================================
// Controller registers on the AXI4-Lite side (byte offsets)
`define LDC_REG_CMD 8'h00
`define LDC_REG_WDATA_LO 8'h04
`define LDC_REG_WDATA_HI 8'h08
`define LDC_REG_RDATA_LO 8'h0C
`define LDC_REG_RDATA_HI 8'h10
`define LDC_REG_STATUS 8'h14
`define LDC_REG_DIVIDE 8'h18
`define LDC_DIV_RST 8'h04

// ==========================================
// Link framing
`define LDC_CMD_BITS 16
`define LDC_DATA_BITS 48
`define LDC_FRAME_BITS 64

`endif

/* File: include/ldc_pkg.sv */
// Purpose: Types shared by both ends of the LED command link
// Assumes: Constants live in ldc_map.svh
// Notes: Command kinds as one-hot codes
package ldc_pkg;
	typedef enum logic [3:0] {
		LDC_K_NONE = 4'b0001,
		LDC_K_WRITE = 4'b0010,
		LDC_K_READ = 4'b0100,
		LDC_K_ACTION = 4'b1000
	} ldc_kind_e;
	typedef logic [47:0] ldc_word_t;
endpackage

/* File: include/ldc_link_if.sv */
// Purpose: Three-wire link between controller and LED driver bank
// Assumes: Controller makes the link clock
// Notes: Each wire has one driver, so no enables are needed
`timescale 1ns/1ps
interface ldc_link_if;
	logic sclk;
	logic sin;
	logic sout;
	modport ctrl (output sclk, output sin, input sout);
	modport dev (input sclk, input sin, output sout);
endinterface

/* File: design/ldc_sync.sv */
// Purpose: Two-flop synchroniser for link pins
// Assumes: One clock, synchronous active-low reset
// Notes: First stage read only by the second
`timescale 1ns/1ps
module ldc_sync #(
	parameter int W = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;

	// ==========================================
	// Two stages
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			q <= '0;
		end else begin
			s1_r <= d;
			q <= s1_r;
		end
	end
endmodule

/* File: design/ldc_dev.sv */
// Purpose: Command-addressed register bank of the LED driver, link side
// Assumes: 64-bit frames: 16-bit command then 48-bit data, MSB first, sampled on sclk rise
// Notes: Read frames return data on sout during the 48 data bits of the same frame
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ldc_map.svh"
module ldc_dev
	import ldc_pkg::*;
#(
	parameter int MEM_WORDS = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	ldc_link_if.dev link,
	input wire logic [15:0] open_line_flags_upper,
	input wire logic [47:0] open_line_flags_lower,
	input wire logic [15:0] short_line_flags_upper,
	input wire logic [47:0] short_line_flags_lower,
	input wire logic [47:0] open_channel_flags,
	input wire logic [47:0] short_channel_flags,
	output logic [47:0] common_config_word0,
	output logic [5:0] open_check_line_select,
	output logic [5:0] short_check_line_select,
	output logic predischarge_enable,
	output logic [5:0] cascade_count,
	output logic [6:0] scan_lines,
	output logic bank_select,
	output logic standby,
	output logic power_save,
	output logic [47:0] mem_rd_data,
	input wire logic [3:0] mem_rd_addr
);
	typedef struct packed {
		logic sclk_d;
		logic [5:0] bitcnt;
		logic [15:0] cmd;
		logic [47:0] data;
		logic [47:0] rsh;
		ldc_kind_e kind;
		logic sout;
		logic [47:0] cfg0;
		logic [5:0] osel;
		logic [5:0] ssel;
		logic bank;
		logic sby;
		logic psv;
		logic [3:0] wptr;
	} ldc_dev_s;

	ldc_dev_s st_r;
	ldc_dev_s st_nxt;
	logic [1:0] pins;
	logic [47:0] mem_a [MEM_WORDS];
	logic [47:0] mem_b [MEM_WORDS];
	logic rise;
	logic [15:0] cmd_full;
	logic [47:0] rd_word;
	logic mem_we;

	// ==========================================
	// Pin synchronisation
	ldc_sync #(.W(2)) i_ldc_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({link.sclk, link.sin}),
		.q(pins)
	);

	// Decode a command word into its kind
	function automatic ldc_kind_e kind_of(input logic [15:0] c);
		unique case (c)
			`LDC_CMD_CFG0_WR, `LDC_CMD_OPEN_SEL_WR, `LDC_CMD_SHORT_SEL_WR: kind_of = LDC_K_WRITE;
			`LDC_CMD_CFG0_RD, `LDC_CMD_OPEN_SEL_RD, `LDC_CMD_SHORT_SEL_RD,
			`LDC_CMD_OPEN_UP_RD, `LDC_CMD_OPEN_LO_RD, `LDC_CMD_SHORT_UP_RD,
			`LDC_CMD_SHORT_LO_RD, `LDC_CMD_OPEN_CH_RD,
			`LDC_CMD_SHORT_CH_RD: kind_of = LDC_K_READ;
			`LDC_CMD_VSYNC, `LDC_CMD_PSAVE, `LDC_CMD_STBY_CLEAR, `LDC_CMD_STBY_ENTER,
			`LDC_CMD_SRESET, `LDC_CMD_SRAM: kind_of = LDC_K_ACTION;
			default: kind_of = LDC_K_NONE;
		endcase
	endfunction

	// Read-back value for a read command
	function automatic logic [47:0] read_of(input logic [15:0] c, input ldc_dev_s s);
		case (c)
			`LDC_CMD_CFG0_RD: read_of = s.cfg0;
			`LDC_CMD_OPEN_SEL_RD: read_of = {42'h0, s.osel};
			`LDC_CMD_SHORT_SEL_RD: read_of = {42'h0, s.ssel};
			`LDC_CMD_OPEN_UP_RD: read_of = {32'h0, open_line_flags_upper};
			`LDC_CMD_OPEN_LO_RD: read_of = open_line_flags_lower;
			`LDC_CMD_SHORT_UP_RD: read_of = {32'h0, short_line_flags_upper};
			`LDC_CMD_SHORT_LO_RD: read_of = short_line_flags_lower;
			`LDC_CMD_OPEN_CH_RD: read_of = open_channel_flags;
			`LDC_CMD_SHORT_CH_RD: read_of = short_channel_flags;
			default: read_of = 48'h0;
		endcase
	endfunction

	assign rise = pins[1] & ~st_r.sclk_d;
	assign cmd_full = {st_r.cmd[14:0], pins[0]};
	// Only read commands load read data, anything else shifts out zeros
	assign rd_word = (kind_of(cmd_full) == LDC_K_READ) ? read_of(cmd_full, st_r) : 48'h0;

	// ==========================================
	// Frame shifter and command execution
	always_comb begin
		st_nxt = st_r;
		mem_we = 1'b0;
		st_nxt.sclk_d = pins[1];
		if (rise) begin
			st_nxt.bitcnt = st_r.bitcnt + 6'd1;
			if (st_r.bitcnt < 6'(`LDC_CMD_BITS)) begin
				st_nxt.cmd = cmd_full;
				if (st_r.bitcnt == 6'(`LDC_CMD_BITS - 1)) begin
					st_nxt.kind = kind_of(cmd_full);
					// Bit 47 leaves at once so that all 48 bits fit the data phase
					st_nxt.sout = rd_word[47];
					st_nxt.rsh = {rd_word[46:0], 1'b0};
				end
			end else begin
				st_nxt.data = {st_r.data[46:0], pins[0]};
				st_nxt.sout = st_r.rsh[47];
				st_nxt.rsh = {st_r.rsh[46:0], 1'b0};
			end
			if (st_r.bitcnt == 6'(`LDC_FRAME_BITS - 1)) begin
				st_nxt.sout = 1'b0;
				unique case (st_r.kind)
					LDC_K_WRITE: begin
						case (st_r.cmd)
							`LDC_CMD_CFG0_WR: st_nxt.cfg0 = {st_r.data[46:0], pins[0]};
							`LDC_CMD_OPEN_SEL_WR: st_nxt.osel = {st_r.data[4:0], pins[0]};
							`LDC_CMD_SHORT_SEL_WR: st_nxt.ssel = {st_r.data[4:0], pins[0]};
							default: ;
						endcase
					end
					LDC_K_ACTION: begin
						case (st_r.cmd)
							`LDC_CMD_VSYNC: begin
								st_nxt.bank = ~st_r.bank;
								st_nxt.wptr = 4'h0;
							end
							`LDC_CMD_PSAVE: st_nxt.psv = 1'b1;
							`LDC_CMD_STBY_CLEAR: begin
								st_nxt.sby = 1'b0;
								st_nxt.psv = 1'b0;
							end
							`LDC_CMD_STBY_ENTER: st_nxt.sby = 1'b1;
							`LDC_CMD_SRESET: begin
								// Registers only, memory arrays untouched
								st_nxt.cfg0 = `LDC_CFG0_RST;
								st_nxt.osel = 6'h00;
								st_nxt.ssel = 6'h00;
								st_nxt.bank = 1'b0;
								st_nxt.sby = 1'b0;
								st_nxt.psv = 1'b0;
								st_nxt.wptr = 4'h0;
							end
							default: begin
								mem_we = 1'b1;
								st_nxt.wptr = st_r.wptr + 4'h1;
							end
						endcase
					end
					default: ; // Reads and unknown commands change nothing
				endcase
				st_nxt.kind = LDC_K_NONE;
			end
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '{sclk_d: 1'b0, bitcnt: 6'h0, cmd: 16'h0, data: 48'h0, rsh: 48'h0,
				kind: LDC_K_NONE, sout: 1'b0, cfg0: `LDC_CFG0_RST, osel: 6'h0,
				ssel: 6'h0, bank: 1'b0, sby: 1'b0, psv: 1'b0, wptr: 4'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Grayscale memory, bank that is not displayed receives data
	always_ff @(posedge aclk) begin
		if (mem_we && !st_r.bank) begin
			mem_a[st_r.wptr] <= {st_r.data[46:0], pins[0]};
		end
		if (mem_we && st_r.bank) begin
			mem_b[st_r.wptr] <= {st_r.data[46:0], pins[0]};
		end
	end

	// ==========================================
	// Registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_rd_data <= 48'h0;
			cascade_count <= 6'h08;
			scan_lines <= 7'h01;
			predischarge_enable <= 1'b1;
		end else begin
			mem_rd_data <= st_r.bank ? mem_a[mem_rd_addr] : mem_b[mem_rd_addr];
			cascade_count <= {1'b0, st_r.cfg0[`LDC_CNT_MSB:`LDC_CNT_LSB]} + 6'h01;
			scan_lines <= {1'b0, st_r.cfg0[`LDC_SCAN_MSB:`LDC_SCAN_LSB]} + 7'h01;
			predischarge_enable <= st_r.cfg0[`LDC_PDC_BIT];
		end
	end

	assign link.sout = st_r.sout;
	assign common_config_word0 = st_r.cfg0;
	assign open_check_line_select = st_r.osel;
	assign short_check_line_select = st_r.ssel;
	assign bank_select = st_r.bank;
	assign standby = st_r.sby;
	assign power_save = st_r.psv;
endmodule

/* File: design/ldc_ctrl.sv */
// Purpose: Display controller end: AXI4-Lite registers drive one link frame per command
// Assumes: Writing the command register starts a frame when idle
// Notes: sclk made by dividing aclk; sout sampled through two flops
`timescale 1ns/1ps
`include "ldc_map.svh"
module ldc_ctrl
	import ldc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	ldc_link_if.ctrl link,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic aw_ok;
		logic w_ok;
		logic [7:0] awa;
		logic [31:0] wd;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic [15:0] cmd;
		logic [47:0] wdat;
		logic [47:0] rdat;
		logic [7:0] div;
		logic busy;
		logic [7:0] dcnt;
		logic sclk;
		logic sin;
		logic [6:0] bits;
		logic [63:0] sh;
	} ldc_ctrl_s;

	ldc_ctrl_s st_r;
	ldc_ctrl_s st_nxt;
	logic [0:0] sout_s;

	ldc_sync #(.W(1)) i_ldc_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(link.sout),
		.q(sout_s)
	);

	// ==========================================
	// Bus slave and frame engine
	always_comb begin
		st_nxt = st_r;
		if (s_axi_awvalid && !st_r.aw_ok && !st_r.bv) begin
			st_nxt.aw_ok = 1'b1;
			st_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.w_ok && !st_r.bv) begin
			st_nxt.w_ok = 1'b1;
			st_nxt.wd = s_axi_wdata;
		end
		if (st_r.aw_ok && st_r.w_ok) begin
			st_nxt.aw_ok = 1'b0;
			st_nxt.w_ok = 1'b0;
			st_nxt.bv = 1'b1;
			st_nxt.br = 2'b00;
			case (st_r.awa)
				`LDC_REG_CMD: begin
					if (st_r.busy) begin
						st_nxt.br = 2'b10;
					end else begin
						st_nxt.cmd = st_r.wd[15:0];
						st_nxt.busy = 1'b1;
						st_nxt.bits = 7'h0;
						st_nxt.dcnt = 8'h0;
						st_nxt.sh = {st_r.wd[15:0], st_r.wdat};
						st_nxt.sin = st_r.wd[15];
					end
				end
				`LDC_REG_WDATA_LO: st_nxt.wdat[31:0] = st_r.wd;
				`LDC_REG_WDATA_HI: st_nxt.wdat[47:32] = st_r.wd[15:0];
				`LDC_REG_DIVIDE: st_nxt.div = (st_r.wd[7:0] == 8'h0) ? 8'h01 : st_r.wd[7:0];
				default: st_nxt.br = 2'b10;
			endcase
		end
		if (st_r.bv && s_axi_bready) begin
			st_nxt.bv = 1'b0;
		end
		if (s_axi_arvalid && !st_r.rv) begin
			st_nxt.rv = 1'b1;
			st_nxt.rr = 2'b00;
			case (s_axi_araddr)
				`LDC_REG_CMD: st_nxt.rd = {16'h0, st_r.cmd};
				`LDC_REG_WDATA_LO: st_nxt.rd = st_r.wdat[31:0];
				`LDC_REG_WDATA_HI: st_nxt.rd = {16'h0, st_r.wdat[47:32]};
				`LDC_REG_RDATA_LO: st_nxt.rd = st_r.rdat[31:0];
				`LDC_REG_RDATA_HI: st_nxt.rd = {16'h0, st_r.rdat[47:32]};
				`LDC_REG_STATUS: st_nxt.rd = {31'h0, st_r.busy};
				`LDC_REG_DIVIDE: st_nxt.rd = {24'h0, st_r.div};
				default: begin
					st_nxt.rd = 32'h0;
					st_nxt.rr = 2'b10;
				end
			endcase
		end
		if (st_r.rv && s_axi_rready) begin
			st_nxt.rv = 1'b0;
		end
		// Half-period divider: sin changes on fall, sampled by the device on rise
		if (st_r.busy) begin
			if (st_r.dcnt == st_r.div - 8'h01) begin
				st_nxt.dcnt = 8'h0;
				st_nxt.sclk = ~st_r.sclk;
				if (st_r.sclk) begin
					st_nxt.bits = st_r.bits + 7'h01;
					st_nxt.sh = {st_r.sh[62:0], 1'b0};
					st_nxt.sin = st_r.sh[62];
					if (st_r.bits == 7'(`LDC_FRAME_BITS - 1)) begin
						st_nxt.busy = 1'b0;
						st_nxt.sin = 1'b0;
					end
				end else if (st_r.bits >= 7'(`LDC_CMD_BITS)) begin
					// Bit shown after the previous rise is taken at this rise, 48 in all
					st_nxt.rdat = {st_r.rdat[46:0], sout_s[0]};
				end
			end else begin
				st_nxt.dcnt = st_r.dcnt + 8'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.div <= `LDC_DIV_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign link.sclk = st_r.sclk;
	assign link.sin = st_r.sin;
	assign s_axi_awready = !st_r.aw_ok && !st_r.bv;
	assign s_axi_wready = !st_r.w_ok && !st_r.bv;
	assign s_axi_bvalid = st_r.bv;
	assign s_axi_bresp = st_r.br;
	assign s_axi_arready = !st_r.rv;
	assign s_axi_rvalid = st_r.rv;
	assign s_axi_rdata = st_r.rd;
	assign s_axi_rresp = st_r.rr;
endmodule

/* File: sim/ldc_link_properties.sv */
// Purpose: Properties of the LED command link and the bank outputs
// Assumes: Link divider left at its reset value of four cycles
// Notes: Bank state may only move shortly after a link clock rise
`timescale 1ns/1ps
module ldc_link_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic sin,
	input wire logic sout,
	input wire logic [47:0] common_config_word0,
	input wire logic predischarge_enable,
	input wire logic [5:0] cascade_count,
	input wire logic [6:0] scan_lines,
	input wire logic bank_select,
	input wire logic standby,
	input wire logic power_save
);
	logic sclk_q;
	logic [7:0] since_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================
	// Cycles since the last link clock rise, saturating
	always_ff @(posedge aclk) begin
		sclk_q <= sclk;
		if (!aresetn)
			since_r <= 8'hFF;
		else if (sclk && !sclk_q)
			since_r <= 8'h00;
		else if (since_r != 8'hFF)
			since_r <= since_r + 8'h01;
	end
	// ==========================================
	// Link wire shape
	sclk_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high phase wrong");
	sclk_low_a: assert property ($fell(sclk) |-> !sclk [*4])
		else $error("link clock low phase too short");
	sin_hold_a: assert property (sclk && $past(sclk) |-> $stable(sin))
		else $error("data line moved while clock high");
	// ==========================================
	// Field decoding of the first configuration word
	count_map_a: assert property ($stable(common_config_word0) |->
		cascade_count == {1'h0, common_config_word0[4:0]} + 6'h01)
		else $error("cascade count does not follow its field");
	pdc_map_a: assert property ($stable(common_config_word0) |->
		predischarge_enable == common_config_word0[8])
		else $error("pre-discharge does not follow its bit");
	scan_map_a: assert property ($stable(common_config_word0) |->
		scan_lines == {1'h0, common_config_word0[21:16]} + 7'h01)
		else $error("scan line count does not follow its field");
	// ==========================================
	// State moves only right after a received clock rise
	cfg_update_a: assert property ($changed(common_config_word0) |-> since_r < 8'h08)
		else $error("config word changed outside a frame");
	standby_upd_a: assert property ($changed(standby) |-> since_r < 8'h08)
		else $error("standby changed outside a frame");
	bank_update_a: assert property ($changed(bank_select) |-> since_r < 8'h08)
		else $error("bank select changed outside a frame");
	psave_update_a: assert property ($changed(power_save) |-> since_r < 8'h08)
		else $error("power save changed outside a frame");
	// Main scenarios reached
	cover property ($rose(standby));
	cover property ($rose(bank_select));
	cover property ($fell(predischarge_enable));
	cover property (sclk && sout);
endmodule

/* File: sim/tb_led_driver_command_register_map.sv */
// Purpose: Drives the controller registers and checks the LED bank across the link
// Assumes: Divider left at four, single device on the link
// Notes: Read expectations are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`include "ldc_map.svh"
module tb_led_driver_command_register_map;
	localparam logic [47:0] CFG_NEW = (`LDC_CFG0_RST & ~48'h0000_0000_0100) | 48'h0000_003F_0018;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [47:0] flg [6] = '{default: 48'h0};
	logic [47:0] cfg, mrd, word;
	logic [5:0] osel, ssel, cnt;
	logic [6:0] scn;
	logic pdc, bank, sby, psv;
	logic [32:0] exp_q [$];
	logic [32:0] note;
	logic [1:0] rresp, last_rresp;
	int bad_count = 0, checked = 0, seed = 64830;
	ldc_link_if lnk ();
	// Clock
	always #25 aclk = ~aclk;
	ldc_dev i_ldc_dev (.aclk(aclk), .aresetn(aresetn), .link(lnk),
		.open_line_flags_upper(flg[0][15:0]), .open_line_flags_lower(flg[1]),
		.short_line_flags_upper(flg[2][15:0]), .short_line_flags_lower(flg[3]),
		.open_channel_flags(flg[4]), .short_channel_flags(flg[5]),
		.common_config_word0(cfg), .open_check_line_select(osel),
		.short_check_line_select(ssel), .predischarge_enable(pdc), .cascade_count(cnt),
		.scan_lines(scn), .bank_select(bank), .standby(sby), .power_save(psv),
		.mem_rd_data(mrd), .mem_rd_addr(4'h0));
	ldc_ctrl i_ldc_ctrl (.aclk(aclk), .aresetn(aresetn), .link(lnk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ldc_link_properties i_ldc_link_properties (.aclk(aclk), .aresetn(aresetn),
		.sclk(lnk.sclk), .sin(lnk.sin), .sout(lnk.sout), .common_config_word0(cfg),
		.predischarge_enable(pdc), .cascade_count(cnt), .scan_lines(scn),
		.bank_select(bank), .standby(sby), .power_save(psv));
	// Compare and count
	task automatic chk(input logic [47:0] seen, input logic [47:0] want);
		checked++;
		if (seen !== want) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	// AXI write, both channels offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge aclk);
			aw = aw | awready;
			w = w | wready;
			if (aw) awvalid <= 1'h0;
			if (w) wvalid <= 1'h0;
		end
		while (!bvalid) @(posedge aclk);
		bready <= 1'h0;
	endtask
	// AXI read, expectation queued for the monitor (bit 32 set means ignore)
	task automatic axr(input logic [7:0] a, input logic [32:0] want, output logic [31:0] got);
		exp_q.push_back(want);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		got = rdata;
		last_rresp = rresp;
		rready <= 1'h0;
	endtask
	// One link frame, then wait while busy
	task automatic frame(input logic [15:0] c, input logic [47:0] d);
		logic [31:0] st;
		axw(8'h04, d[31:0]);
		axw(8'h08, {16'h0000, d[47:32]});
		axw(8'h00, {16'h0000, c});
		st = 32'h0000_0001;
		for (int i = 0; i < 400 && st[0]; i++) axr(8'h14, 33'h1_0000_0000, st);
		// A frame that never ends counts as a mismatch and closes the run
		if (st[0]) begin
			bad_count++;
			$display("MISMATCH t=%0t frame stayed busy", $time);
			complete_run();
		end
		repeat (8) @(posedge aclk);
	endtask
	// Read frame and both result words
	task automatic rd(input logic [15:0] c, input logic [47:0] want);
		logic [31:0] st;
		frame(c, 48'h0);
		axr(8'h0C, {1'h0, want[31:0]}, st);
		axr(8'h10, {17'h0, want[47:32]}, st);
	endtask
	task automatic complete_run();
		$display("counts: checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Monitor: oldest expectation against each read answer
	always @(posedge aclk) begin
		if (rvalid && rready && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			if (!note[32]) chk(rdata, note[31:0]);
		end
	end
	// Watchdog
	initial begin
		repeat (60000) @(posedge aclk);
		bad_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		logic [5:0] sel [2];
		logic [31:0] got;
		repeat (10) @(posedge aclk);
		for (int i = 0; i < 6; i++) flg[i] <= 48'({$random(seed), $random(seed)});
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk(cfg, `LDC_CFG0_RST);
		chk(cnt, 6'h08);
		chk(pdc, 1'h1);
		chk(scn, 7'h01);
		axr(8'h18, {25'h0, `LDC_DIV_RST}, got);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			sel[i] = 6'($random(seed));
			frame(16'hAA0E + 16'(i), {42'h0, sel[i]});
			rd(16'hAA6E + 16'(i), {42'h0, sel[i]});
		end
		chk(osel, sel[0]);
		chk(ssel, sel[1]);
		$display("test selects done");
		for (int i = 0; i < 6; i++) begin
			word = (i < 4 && i % 2 == 0) ? {32'h0, flg[i][15:0]} : flg[i];
			rd(16'hAAA0 + 16'(i), word);
		end
		frame(16'hAAA1, 48'hFFFF_FFFF_FFFF);
		rd(16'hAAA1, flg[1]);
		chk(cfg, `LDC_CFG0_RST);
		$display("test flags done");
		frame(16'hAA00, CFG_NEW);
		chk(cnt, 6'h20);
		chk(pdc, 1'h0);
		chk(scn, 7'h40);
		rd(16'hAA60, CFG_NEW);
		$display("test config done");
		frame(16'hAA90, 48'h0);
		chk(psv, 1'h1);
		frame(16'hAAB1, 48'h0);
		chk(sby, 1'h1);
		frame(16'hAAB0, 48'h0);
		chk(sby, 1'h0);
		chk(psv, 1'h0);
		$display("test actions done");
		word = 48'({$random(seed), $random(seed)});
		frame(16'hAA30, word);
		frame(16'hAAF0, 48'h0);
		chk(bank, 1'h1);
		chk(mrd, word);
		frame(16'hAA80, 48'h0);
		chk(cfg, `LDC_CFG0_RST);
		chk(osel, 6'h00);
		chk(bank, 1'h0);
		frame(16'hAAF0, 48'h0);
		chk(mrd, word);
		axr(8'h1C, 33'h0, got);
		chk(last_rresp, 2'b10);
		$display("test memory done");
		complete_run();
	end
endmodule
